/* hdl/nvac_pkg.sv */
package nvac_pkg;

   // register indices on the plain port
   localparam logic [2:0] ADDR_CONTROL  = 3'h0;
   localparam logic [2:0] ADDR_UNLOCK   = 3'h1;
   localparam logic [2:0] ADDR_ADDRESS  = 3'h2;
   localparam logic [2:0] ADDR_BYTE     = 3'h3;
   localparam logic [2:0] ADDR_FLAGTWO  = 3'h4;

   // control register field positions
   localparam int BIT_SPACE   = 7;
   localparam int BIT_CONFIG  = 6;
   localparam int BIT_UNUSED  = 5;
   localparam int BIT_ROWERA  = 4;
   localparam int BIT_ABORT   = 3;
   localparam int BIT_PERMIT  = 2;
   localparam int BIT_LAUNCH  = 1;
   localparam int BIT_FETCH   = 0;
   localparam int BIT_DONE    = 4;   // done flag in second flag register

   // unlock key values
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // reset values
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [7:0] ADDRESS_RST = 8'h00;

   // self-timed write length
   localparam int unsigned WRITE_TIME_NS = 4000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      UNLOCK_IDLE,
      UNLOCK_GOT_FIRST,
      UNLOCK_ARMED
   } nvac_unlock_e;

   typedef enum logic [1:0] {
      TGT_EEPROM,
      TGT_FLASH,
      TGT_CONFIG
   } nvac_target_e;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_BYTE_WRITE,
      OP_ROW_ERASE,
      OP_FLASH_WRITE
   } nvac_op_e;

   // control register contents
   typedef struct packed {
      logic spaceSelect;
      logic configSpaceSelect;
      logic rowEraseEnable;
      logic abortFlag;
      logic modifyPermit;
      logic cycleLaunch;
   } nvac_ctrl_s;

   // request to the memory arrays
   typedef struct packed {
      logic         readStrobe;
      logic         writeBusy;
      nvac_op_e     op;
      nvac_target_e target;
      logic [7:0]   address;
      logic [7:0]   data;
   } nvac_mem_s;

   // whole block state
   typedef struct packed {
      nvac_ctrl_s   ctrl;
      nvac_unlock_e unlock;
      logic [7:0]   address;
      logic [7:0]   byteData;
      logic         doneFlag;
      logic [15:0]  timer;
      nvac_op_e     op;
      logic         readPend;
      logic [7:0]   rdata;
      nvac_mem_s    mem;
   } nvac_state_s;

endpackage

/* hdl/nvac_eeprom_access_control.sv */
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
module nvac_eeprom_access_control #(
   parameter int unsigned WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic [2:0]         regAddr,
   input  wire logic [7:0]         regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [7:0]         regRdata,
   input  wire logic [7:0]         eepromRdata,
   input  wire logic               arrayDone,
   output nvac_pkg::nvac_mem_s     memReq,
   output logic                    nvmDone
);

   nvac_pkg::nvac_state_s st_r;
   nvac_pkg::nvac_state_s st_nxt;
   logic                  wrUnlock;
   logic                  busy;

   // pick the array from the two select bits
   function automatic nvac_pkg::nvac_target_e targetOf(input nvac_pkg::nvac_ctrl_s c);
      if (c.configSpaceSelect)
         return nvac_pkg::TGT_CONFIG;
      else if (c.spaceSelect)
         return nvac_pkg::TGT_FLASH;
      else
         return nvac_pkg::TGT_EEPROM;
   endfunction

   // control register image, bit 5 forced low
   function automatic logic [7:0] packCtrl(input nvac_pkg::nvac_ctrl_s c);
      logic [7:0] v;
      v = 8'h00;
      v[nvac_pkg::BIT_SPACE]  = c.spaceSelect;
      v[nvac_pkg::BIT_CONFIG] = c.configSpaceSelect;
      v[nvac_pkg::BIT_UNUSED] = 1'b0;
      v[nvac_pkg::BIT_ROWERA] = c.rowEraseEnable;
      v[nvac_pkg::BIT_ABORT]  = c.abortFlag;
      v[nvac_pkg::BIT_PERMIT] = c.modifyPermit;
      v[nvac_pkg::BIT_LAUNCH] = c.cycleLaunch;
      v[nvac_pkg::BIT_FETCH]  = 1'b0;  // fetch never lingers past one cycle
      return v;
   endfunction

   assign wrUnlock  = regWrite && (regAddr == nvac_pkg::ADDR_UNLOCK);
   assign busy      = st_r.ctrl.cycleLaunch;

   //////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.mem.readStrobe = 1'b0;
      st_nxt.readPend = 1'b0;

      // unlock sequence tracker; any other register write breaks it
      if (wrUnlock) begin
         case (st_r.unlock)
            nvac_pkg::UNLOCK_IDLE:
               st_nxt.unlock = (regWdata == nvac_pkg::KEY_FIRST) ?
                               nvac_pkg::UNLOCK_GOT_FIRST : nvac_pkg::UNLOCK_IDLE;
            nvac_pkg::UNLOCK_GOT_FIRST:
               st_nxt.unlock = (regWdata == nvac_pkg::KEY_SECOND) ?
                               nvac_pkg::UNLOCK_ARMED : nvac_pkg::UNLOCK_IDLE;
            nvac_pkg::UNLOCK_ARMED:
               st_nxt.unlock = (regWdata == nvac_pkg::KEY_FIRST) ?
                               nvac_pkg::UNLOCK_GOT_FIRST : nvac_pkg::UNLOCK_IDLE;
            default:
               st_nxt.unlock = nvac_pkg::UNLOCK_IDLE;
         endcase
      end else if (regWrite) begin
         st_nxt.unlock = nvac_pkg::UNLOCK_IDLE;
      end

      // read data captured one cycle after the fetch request
      if (st_r.readPend) begin
         st_nxt.byteData = eepromRdata;
      end

      // software register writes, frozen while a write cycle runs
      if (regWrite && !busy) begin
         case (regAddr)
            nvac_pkg::ADDR_ADDRESS:
               st_nxt.address = regWdata;
            nvac_pkg::ADDR_BYTE:
               st_nxt.byteData = regWdata;
            nvac_pkg::ADDR_CONTROL: begin
               st_nxt.ctrl.spaceSelect       = regWdata[nvac_pkg::BIT_SPACE];
               st_nxt.ctrl.configSpaceSelect = regWdata[nvac_pkg::BIT_CONFIG];
               st_nxt.ctrl.rowEraseEnable    = regWdata[nvac_pkg::BIT_ROWERA];
               st_nxt.ctrl.modifyPermit      = regWdata[nvac_pkg::BIT_PERMIT];
               // abort flag is software writable so it can be cleared
               st_nxt.ctrl.abortFlag         = regWdata[nvac_pkg::BIT_ABORT];
               // fetch: only for eeprom, set-only, self-clearing
               if (regWdata[nvac_pkg::BIT_FETCH] && !regWdata[nvac_pkg::BIT_SPACE]
                   && !regWdata[nvac_pkg::BIT_CONFIG]) begin
                  st_nxt.mem.readStrobe = 1'b1;
                  st_nxt.readPend       = 1'b1;
               end
               // launch: set only, needs permit from an earlier write and unlock
               if (regWdata[nvac_pkg::BIT_LAUNCH]) begin
                  if (st_r.ctrl.modifyPermit && regWdata[nvac_pkg::BIT_PERMIT]
                      && st_r.unlock == nvac_pkg::UNLOCK_ARMED) begin
                     st_nxt.ctrl.cycleLaunch = 1'b1;
                     st_nxt.ctrl.abortFlag   = 1'b1;
                     st_nxt.timer            = 16'(WRITE_CYCLES);
                     if (targetOf(st_nxt.ctrl) == nvac_pkg::TGT_EEPROM)
                        st_nxt.op = nvac_pkg::OP_BYTE_WRITE;
                     else if (regWdata[nvac_pkg::BIT_ROWERA])
                        st_nxt.op = nvac_pkg::OP_ROW_ERASE;
                     else
                        st_nxt.op = nvac_pkg::OP_FLASH_WRITE;
                     st_nxt.mem.writeBusy = 1'b1;
                     st_nxt.mem.op        = st_nxt.op;
                     st_nxt.mem.target    = targetOf(st_nxt.ctrl);
                     st_nxt.mem.address   = st_r.address;
                     st_nxt.mem.data      = st_r.byteData;
                  end else begin
                     st_nxt.ctrl.abortFlag = 1'b1;  // improper attempt
                  end
                  st_nxt.unlock = nvac_pkg::UNLOCK_IDLE;
               end
            end
            default: ;
         endcase
      end

      if (st_nxt.mem.readStrobe) begin
         st_nxt.mem.target  = nvac_pkg::TGT_EEPROM;
         st_nxt.mem.address = st_nxt.address;
      end

      // self-timed cycle: count down, then finish normally
      if (busy) begin
         if (st_r.timer > 16'h0001)
            st_nxt.timer = st_r.timer - 16'h0001;
         else if (arrayDone || st_r.timer == 16'h0001) begin
            st_nxt.timer            = 16'h0000;
            st_nxt.ctrl.cycleLaunch = 1'b0;
            st_nxt.ctrl.abortFlag   = 1'b0;
            st_nxt.doneFlag         = 1'b1;
            st_nxt.mem.writeBusy    = 1'b0;
            st_nxt.mem.op           = nvac_pkg::OP_NONE;
            if (st_r.op == nvac_pkg::OP_ROW_ERASE)
               st_nxt.ctrl.rowEraseEnable = 1'b0;
            st_nxt.op = nvac_pkg::OP_NONE;
         end
      end

      // software clears the done flag; a completion the same cycle wins
      if (regWrite && regAddr == nvac_pkg::ADDR_FLAGTWO && !regWdata[nvac_pkg::BIT_DONE]
          && !(busy && st_r.timer == 16'h0001)) begin
         st_nxt.doneFlag = 1'b0;
      end
      if (regWrite && regAddr == nvac_pkg::ADDR_FLAGTWO && regWdata[nvac_pkg::BIT_DONE])
         st_nxt.doneFlag = 1'b1;

      // read mux, answered the next cycle
      st_nxt.rdata = 8'h00;
      if (regRead) begin
         case (regAddr)
            nvac_pkg::ADDR_CONTROL: st_nxt.rdata = packCtrl(st_r.ctrl);
            nvac_pkg::ADDR_UNLOCK:  st_nxt.rdata = 8'h00;
            nvac_pkg::ADDR_ADDRESS: st_nxt.rdata = st_r.address;
            nvac_pkg::ADDR_BYTE:    st_nxt.rdata = st_r.byteData;
            nvac_pkg::ADDR_FLAGTWO: st_nxt.rdata = {3'h0, st_r.doneFlag, 4'h0};
            default:                st_nxt.rdata = 8'h00;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // state register; a reset mid-write leaves the abort flag set
   // the abort flag and selects are not cleared by rst so that software can trace
   // the failure; a true power-up must clear them through the power-on reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r.ctrl.cycleLaunch    <= 1'b0;
         st_r.ctrl.modifyPermit   <= 1'b0;
         st_r.ctrl.rowEraseEnable <= 1'b0;
         st_r.unlock              <= nvac_pkg::UNLOCK_IDLE;
         st_r.address             <= nvac_pkg::ADDRESS_RST;
         st_r.byteData            <= nvac_pkg::BYTE_RST;
         st_r.doneFlag            <= 1'b0;
         st_r.timer               <= 16'h0000;
         st_r.op                  <= nvac_pkg::OP_NONE;
         st_r.readPend            <= 1'b0;
         st_r.rdata               <= 8'h00;
         st_r.mem                 <= '0;
         st_r.ctrl.abortFlag      <= 1'b1;
         // selects take no reset value so a failed target stays traceable
      end else begin
         st_r.ctrl.cycleLaunch    <= st_nxt.ctrl.cycleLaunch;
         st_r.ctrl.modifyPermit   <= st_nxt.ctrl.modifyPermit;
         st_r.ctrl.rowEraseEnable <= st_nxt.ctrl.rowEraseEnable;
         st_r.unlock              <= st_nxt.unlock;
         st_r.address             <= st_nxt.address;
         st_r.byteData            <= st_nxt.byteData;
         st_r.doneFlag            <= st_nxt.doneFlag;
         st_r.timer               <= st_nxt.timer;
         st_r.op                  <= st_nxt.op;
         st_r.readPend            <= st_nxt.readPend;
         st_r.rdata               <= st_nxt.rdata;
         st_r.mem                 <= st_nxt.mem;
         st_r.ctrl.abortFlag         <= st_nxt.ctrl.abortFlag;
         st_r.ctrl.spaceSelect       <= st_nxt.ctrl.spaceSelect;
         st_r.ctrl.configSpaceSelect <= st_nxt.ctrl.configSpaceSelect;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign regRdata = st_r.rdata;
   assign memReq   = st_r.mem;
   assign nvmDone  = st_r.doneFlag;

endmodule // nvac_eeprom_access_control

/* tb/nvac_checker_asserts.sv */
`timescale 1ns/10ps
module nvac_checker #(
   parameter int unsigned WRITE_CYCLES = 8
) (
   input wire logic                core_clk,
   input wire logic                rst,
   input wire logic [2:0]          regAddr,
   input wire logic [7:0]          regWdata,
   input wire logic                regWrite,
   input wire logic                regRead,
   input wire logic [7:0]          regRdata,
   input wire nvac_pkg::nvac_mem_s memReq,
   input wire logic                nvmDone
);
   localparam int WCM = WRITE_CYCLES - 1;
   logic gotFirst_r;
   logic armed_r;
   wire logic unlockWr = regWrite && regAddr == nvac_pkg::ADDR_UNLOCK;
   wire logic ctrlWr   = regWrite && regAddr == nvac_pkg::ADDR_CONTROL;
   //////////////////////////////////////////////////////////////////////////////
   // key tracker; idle cycles keep it, any other register write breaks it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gotFirst_r <= 1'b0;
         armed_r    <= 1'b0;
      end else if (regWrite) begin
         gotFirst_r <= unlockWr && regWdata == nvac_pkg::KEY_FIRST;
         armed_r    <= unlockWr && regWdata == nvac_pkg::KEY_SECOND && gotFirst_r;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence busy_run;
      ##WCM memReq.writeBusy;
   endsequence
   sequence busy_end;
      ##1 !memReq.writeBusy && nvmDone;
   endsequence
   a_write_length: assert property ($rose(memReq.writeBusy) |-> busy_run ##0 busy_end)
      else $error("self-timed write length wrong");
   a_key_needed: assert property (ctrlWr && regWdata[1] && !armed_r |=> !$rose(memReq.writeBusy))
      else $error("write started without key sequence");
   a_fetch_starts: assert property (ctrlWr && regWdata[0] && !regWdata[7] && !regWdata[6] && !memReq.writeBusy
      |=> memReq.readStrobe)
      else $error("fetch gave no array read");
   a_fetch_refused: assert property (ctrlWr && (regWdata[7] || regWdata[6]) |=> !memReq.readStrobe)
      else $error("fetch accepted outside eeprom");
   a_unlock_zero: assert property (regRead && regAddr == nvac_pkg::ADDR_UNLOCK |=> regRdata == 8'h00)
      else $error("unlock port read not zero");
   a_ctrl_fixed: assert property (regRead && regAddr == nvac_pkg::ADDR_CONTROL |=> !regRdata[5] && !regRdata[0])
      else $error("control fixed bits not zero");
   a_done_holds: assert property (nvmDone && !(regWrite && regAddr == nvac_pkg::ADDR_FLAGTWO && !regWdata[4])
      |=> nvmDone)
      else $error("done flag dropped on its own");
   a_flag_read: assert property (regRead && regAddr == nvac_pkg::ADDR_FLAGTWO
      |=> regRdata == {3'h0, $past(nvmDone), 4'h0})
      else $error("flag two read wrong");
   a_busy_op: assert property ($rose(memReq.writeBusy) |-> memReq.op != nvac_pkg::OP_NONE)
      else $error("write busy without operation");
endmodule // nvac_checker

/* tb/nvac_array_model.sv */
`timescale 1ns/10ps
module nvac_array_model (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire nvac_pkg::nvac_mem_s memReq,
   output logic      [7:0]          eepromRdata,
   output logic                     arrayDone
);
   logic [7:0] cells [256];
   logic [7:0] pendAddr, pendData, rdAddr, lastOut;
   logic       pendValid, busyQ, readQ;
   // the block's own timer sets the length, no early finish
   assign arrayDone = 1'b0;
   // read data only around the strobe, a changing pattern otherwise
   assign eepromRdata = memReq.readStrobe ? cells[memReq.address] : readQ ? cells[rdAddr] : ~lastOut;
   //////////////////////////////////////////////////////////////////////////////
   // eeprom byte writes erase on entry, program on exit; a reset mid-cycle clears every cell to 00
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busyQ     <= 1'b0;
         readQ     <= 1'b0;
         pendValid <= 1'b0;
         lastOut   <= 8'h00;
         for (int i = 0; i < 256; i++) cells[i] <= 8'h00;
      end else begin
         busyQ   <= memReq.writeBusy;
         readQ   <= memReq.readStrobe;
         lastOut <= eepromRdata;
         if (memReq.readStrobe) rdAddr <= memReq.address;
         if (memReq.writeBusy && !busyQ && memReq.op == nvac_pkg::OP_BYTE_WRITE
             && memReq.target == nvac_pkg::TGT_EEPROM) begin
            cells[memReq.address] <= 8'hff;
            pendAddr  <= memReq.address;
            pendData  <= memReq.data;
            pendValid <= 1'b1;
         end
         if (!memReq.writeBusy && busyQ && pendValid) begin
            cells[pendAddr] <= pendData;
            pendValid       <= 1'b0;
         end
      end
   end
endmodule // nvac_array_model

/* tb/nvac_eeprom_access_control_bench.sv */
`timescale 1ns/10ps
module nvac_eeprom_access_control_bench;
   localparam int unsigned WC = 8;
   localparam logic [2:0] CTL = nvac_pkg::ADDR_CONTROL;
   localparam logic [2:0] UNL = nvac_pkg::ADDR_UNLOCK;
   localparam logic [2:0] ADR = nvac_pkg::ADDR_ADDRESS;
   localparam logic [2:0] BYT = nvac_pkg::ADDR_BYTE;
   localparam logic [2:0] FL2 = nvac_pkg::ADDR_FLAGTWO;
   logic                core_clk = 1'b0;
   logic                rst      = 1'b1;
   logic [2:0]          regAddr  = 3'h0;
   logic [7:0]          regWdata = 8'h00;
   logic                regWrite = 1'b0;
   logic                regRead  = 1'b0;
   logic [7:0]          regRdata, eepromRdata;
   logic                arrayDone, nvmDone;
   nvac_pkg::nvac_mem_s memReq;
   int                  errors = 0;
   int                  comparisons = 0;
   int                  strobes = 0;
   always #2 core_clk = ~core_clk;
   nvac_eeprom_access_control #(.WRITE_CYCLES(WC)) i_nvac_eeprom_access_control (.core_clk(core_clk), .rst(rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .eepromRdata(eepromRdata), .arrayDone(arrayDone), .memReq(memReq), .nvmDone(nvmDone));
   nvac_array_model i_nvac_array_model (.core_clk(core_clk), .rst(rst), .memReq(memReq),
      .eepromRdata(eepromRdata), .arrayDone(arrayDone));
   // count array read strobes seen at the port
   always @(negedge core_clk) if (memReq.readStrobe === 1'b1) strobes++;
   //////////////////////////////////////////////////////////////////////////////
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // strobe left high so back-to-back writes keep it high with no gap between them
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      regRead  <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic idle(input int n);
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
      regAddr  <= a;
      regRead  <= 1'b1;
      regWrite <= 1'b0;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 check8(what, exp, regRdata);
      @(posedge core_clk);
   endtask
   task automatic launch(input logic [7:0] c);
      wr(UNL, nvac_pkg::KEY_FIRST);
      wr(UNL, nvac_pkg::KEY_SECOND);
      wr(CTL, c);
   endtask
   task automatic finish(input logic [7:0] c);
      int n;
      n = 0;
      idle(0);
      while (nvmDone !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      rdc("control", CTL, c);
      rdc("flag two", FL2, 8'h10);
      wr(FL2, 8'h00);
      rdc("flag two", FL2, 8'h00);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      // selects have no reset value; give them one before looking
      wr(CTL, 8'h08);
      rdc("control", CTL, 8'h08);
      rdc("address", ADR, 8'h00);
      rdc("byte", BYT, 8'h00);
      wr(UNL, nvac_pkg::KEY_FIRST);
      rdc("unlock", UNL, 8'h00);
      wr(CTL, 8'h24);
      rdc("control", CTL, 8'h04);
      $display("test reset done");
   endtask
   task automatic t_refuse;
      wr(CTL, 8'h00);
      launch(8'h06);
      rdc("control", CTL, 8'h0c);
      wr(CTL, 8'h04);
      wr(CTL, 8'h06);
      rdc("control", CTL, 8'h0c);
      check8("write busy", 8'h00, {7'h0, memReq.writeBusy});
      $display("test refuse done");
   endtask
   task automatic t_byte_write;
      wr(ADR, 8'hff);
      wr(BYT, 8'h5a);
      wr(CTL, 8'h04);
      launch(8'h06);
      idle(1);
      check8("op", {6'h0, nvac_pkg::OP_BYTE_WRITE}, {6'h0, memReq.op});
      check8("target", {6'h0, nvac_pkg::TGT_EEPROM}, {6'h0, memReq.target});
      check8("address", 8'hff, memReq.address);
      check8("data", 8'h5a, memReq.data);
      rdc("control", CTL, 8'h0e);
      wr(ADR, 8'h11);
      wr(BYT, 8'h33);
      wr(CTL, 8'h00);
      finish(8'h04);
      rdc("address", ADR, 8'hff);
      $display("test byte write done");
   endtask
   task automatic t_fetch;
      int s0;
      s0 = strobes;
      wr(CTL, 8'h05);
      idle(1);
      rdc("byte", BYT, 8'h5a);
      rdc("byte", BYT, 8'h5a);
      rdc("control", CTL, 8'h04);
      wr(CTL, 8'h81);
      wr(CTL, 8'h41);
      idle(2);
      check8("strobes", s0[7:0] + 8'h01, strobes[7:0]);
      $display("test fetch done");
   endtask
   task automatic t_flash;
      logic [7:0] pre [3] = '{8'h94, 8'h84, 8'hc4};
      logic [7:0] post [3] = '{8'h84, 8'h84, 8'hc4};
      logic [1:0] ops [2] = '{nvac_pkg::OP_ROW_ERASE, nvac_pkg::OP_FLASH_WRITE};
      logic [1:0] tgt [3] = '{nvac_pkg::TGT_FLASH, nvac_pkg::TGT_FLASH, nvac_pkg::TGT_CONFIG};
      for (int i = 0; i < 3; i++) begin
         wr(CTL, pre[i]);
         launch(pre[i] | 8'h02);
         idle(1);
         if (i < 2) check8("op", {6'h0, ops[i]}, {6'h0, memReq.op});
         check8("target", {6'h0, tgt[i]}, {6'h0, memReq.target});
         finish(post[i]);
      end
      $display("test flash done");
   endtask
   task automatic t_abort;
      wr(CTL, 8'h84);
      launch(8'h86);
      idle(2);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc("control", CTL, 8'h88);
      check8("write busy", 8'h00, {7'h0, memReq.writeBusy});
      $display("test abort done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_refuse();
      t_byte_write();
      t_fetch();
      t_flash();
      t_abort();
      complete_run();
   end
   // the whole run needs about 140 cycles
   initial begin
      #20000;
      errors++;
      complete_run();
   end
endmodule // nvac_eeprom_access_control_bench
bind nvac_eeprom_access_control nvac_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvac_checker (.core_clk(core_clk),
   .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .memReq(memReq), .nvmDone(nvmDone));
